/* tsw_pkg.sv */
/*
 Constants shared by the time-slot switch pin logic: frame geometry,
 control register fields, host address decode and handshake states.
 Assumes a single 125 MHz system clock that samples every pin.
*/
package tsw_pkg;
	localparam int STREAMS = 8;
	localparam int CHANNELS = 32;
	localparam int CH_BITS = 8;
	localparam int MEM_DEPTH = 256;
	localparam real FRAME_US = 125.0;
	localparam real BIT_CLOCK_MHZ = 4.096;
	localparam int EDGES_PER_CELL = 2;
	localparam int EDGE_CNT_W = 9;
	localparam logic [EDGE_CNT_W-1:0] EDGE_CNT_RST = 9'h000;
	// Edge counter fields: [0] half cell, [3:1] bit slot, [8:4] channel
	localparam int EC_SLOT_LSB = 1;
	localparam int EC_SLOT_MSB = 3;
	localparam int EC_CHAN_LSB = 4;
	localparam int EC_CHAN_MSB = 8;
	localparam logic [2:0] SLOT_LAST = 3'h7;
	localparam logic [4:0] CHAN_ONE = 5'h01;
	// Control register fields
	localparam int CR_SPLIT_BIT = 7;
	localparam int CR_MSG_ALL_BIT = 6;
	localparam int CR_MSEL_LSB = 3;
	localparam int CR_MSEL_MSB = 4;
	localparam int CR_STREAM_LSB = 0;
	localparam int CR_STREAM_MSB = 2;
	localparam logic [7:0] CR_RST = 8'h00;
	localparam logic [1:0] MSEL_CMH = 2'h2;
	localparam logic [1:0] MSEL_CML = 2'h3;
	// Connection memory high fields
	localparam int CMH_W = 3;
	localparam int CMH_OE_BIT = 0;
	localparam int CMH_CSO_BIT = 1;
	localparam int CMH_MSG_BIT = 2;
	localparam logic [CMH_W-1:0] CMH_RST = 3'h0;
	localparam logic [7:0] BYTE_RST = 8'h00;
	// Host address: line 5 picks memory over control register
	localparam int ADDR_W = 6;
	localparam int ADDR_MEM_BIT = 5;
	typedef enum logic [2:0] {
		HP_IDLE = 3'b001,
		HP_EXEC = 3'b010,
		HP_ACK = 3'b100
	} tsw_hp_state_e;
endpackage

/* tsw_host_port.sv */
/*
 Host parallel port handshake for the time-slot switch: captures an
 access, issues a write pulse, returns read data and the acknowledge.
 Assumes host pins are synchronous to clk; the core answers read data
 combinationally from the captured address.
*/
`timescale 1ns/1ps
`default_nettype none
module tsw_host_port
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic chip_sel_n,
	input wire logic data_strobe,
	input wire logic read_not_write,
	input wire logic [2:0] host_addr_low,
	input wire logic [2:0] host_addr_high,
	input wire logic [7:0] host_data_in,
	output logic [7:0] host_data_out,
	output logic host_data_oe,
	output logic transfer_ack_n,
	output logic transfer_ack_oe,
	output logic acc_wr,
	output logic [tsw_pkg::ADDR_W-1:0] acc_addr,
	output logic [7:0] acc_wdata,
	input wire logic [7:0] acc_rdata
);
	tsw_pkg::tsw_hp_state_e state_q;
	logic active;
	logic rd_q;
	logic [tsw_pkg::ADDR_W-1:0] addr_q;
	logic [7:0] wdata_q;
	logic [7:0] rdata_q;

	// Strobed only while selected low and strobe high
	assign active = !chip_sel_n && data_strobe; // see R2 see R4

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state_q <= tsw_pkg::HP_IDLE;
		else
		begin
			case (state_q)
				tsw_pkg::HP_IDLE:
					if (active)
						state_q <= tsw_pkg::HP_EXEC;
				tsw_pkg::HP_EXEC:
					state_q <= active ? tsw_pkg::HP_ACK : tsw_pkg::HP_IDLE;
				tsw_pkg::HP_ACK:
					if (!active)
						state_q <= tsw_pkg::HP_IDLE;
				default:
					state_q <= tsw_pkg::HP_IDLE;
			endcase
		end
	end

	// Address and direction are captured once at the start of the strobe
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			addr_q <= '0;
			rd_q <= 1'b0;
			wdata_q <= tsw_pkg::BYTE_RST;
		end
		else if (state_q == tsw_pkg::HP_IDLE && active)
		begin
			addr_q <= {host_addr_high, host_addr_low}; // see R5
			rd_q <= read_not_write; // see R3
			wdata_q <= host_data_in; // see R6
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_q <= tsw_pkg::BYTE_RST;
		else if (state_q == tsw_pkg::HP_EXEC && rd_q)
			rdata_q <= acc_rdata;
	end

	assign acc_addr = addr_q;
	assign acc_wdata = wdata_q;
	// A strobe dropped during execute still completes its write
	assign acc_wr = (state_q == tsw_pkg::HP_EXEC) && !rd_q; // see R3
	assign host_data_out = rdata_q;
	// Data lines released unless a selected, strobed read is acknowledged
	assign host_data_oe = (state_q == tsw_pkg::HP_ACK) && rd_q && active; // see R6 see R16
	// Acknowledge is driven low only once the transfer is done
	assign transfer_ack_n = !(state_q == tsw_pkg::HP_ACK); // see R13
	assign transfer_ack_oe = (state_q == tsw_pkg::HP_ACK); // see R13
endmodule
`default_nettype wire

/* tsw_switch.sv */
/*
 Pin logic of a 256-channel time-slot switch: bit clock timing, frame
 counter, data and connection memories, eight three-state serial output
 streams, control serial output and the host port.
 Assumes the bit clock, frame sync and streams are synchronous to clk,
 which must run well above the 4.096 MHz bit clock.
*/
// Contract
// R1 - A bit cell spans two bit-clock periods, bounded by falling edges.
// R2 - Host data strobe is active high.
// R3 - Read-not-write high reads, low writes.
// R4 - Chip select is active low; no response while it is high.
// R5 - Six address lines are sampled for each host access.
// R6 - Data lines driven on reads, received on writes.
// R7 - Eight three-state serial output streams at 2048 kbit/s.
// R8 - Output drive enable high lets output drivers work normally.
// R9 - Output drive enable low releases all serial outputs; the control serial output has no enable and stays driven.
// R10 - Per-channel software high impedance even with drive enable high.
// R11 - Control serial output sends bit 1 of all 256 high locations.
// R12 - Frame sync low resets the frame counter at the next falling edge.
// R13 - Acknowledge driven low at transfer completion, else released.
// R14 - Address line 5 low selects the control register.
// R15 - Frames hold 32 channels of 8 bits each.
// R16 - Data lines released when deselected or writing.
`timescale 1ns/1ps
`default_nettype none
module tsw_switch
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic bit_clock_4m,
	input wire logic frame_sync_n,
	input wire logic [7:0] serial_in_streams,
	input wire logic output_drive_enable,
	output logic [7:0] serial_out_streams,
	output logic [7:0] serial_out_oe,
	output logic control_serial_out,
	input wire logic chip_sel_n,
	input wire logic data_strobe,
	input wire logic read_not_write,
	input wire logic [2:0] host_addr_low,
	input wire logic [2:0] host_addr_high,
	input wire logic [7:0] host_data_in,
	output logic [7:0] host_data_out,
	output logic host_data_oe,
	output logic transfer_ack_n,
	output logic transfer_ack_oe
);
	logic clk4_q;
	logic fall;
	logic [tsw_pkg::EDGE_CNT_W-1:0] edge_q;
	logic [tsw_pkg::EDGE_CNT_W-1:0] edge_d;
	logic [7:0] ctrl_q;
	logic [tsw_pkg::CMH_W-1:0] cmh_q [tsw_pkg::MEM_DEPTH];
	logic [7:0] cml_q [tsw_pkg::MEM_DEPTH];
	logic [7:0] dmem_q [tsw_pkg::MEM_DEPTH];
	logic [7:0] shift_q [tsw_pkg::STREAMS];
	logic [7:0] out_q;
	logic [7:0] oe_q;
	logic cso_q;
	logic acc_wr;
	logic [tsw_pkg::ADDR_W-1:0] acc_addr;
	logic [7:0] acc_wdata;
	logic [7:0] acc_rdata;
	logic [7:0] mem_idx;
	logic [1:0] msel;
	logic [4:0] chan_d;
	logic [2:0] slot_d;

	function automatic logic [7:0] cm_index(input logic [2:0] stream, input logic [4:0] chan);
		cm_index = {stream, chan};
	endfunction

	// Message mode forced globally or per channel
	function automatic logic is_message(input logic [7:0] idx, input logic [7:0] ctrl);
		is_message = ctrl[tsw_pkg::CR_MSG_ALL_BIT] || cmh_q[idx][tsw_pkg::CMH_MSG_BIT];
	endfunction

	tsw_host_port u_host
	(
		.clk(clk),
		.rst_n(rst_n),
		.chip_sel_n(chip_sel_n),
		.data_strobe(data_strobe),
		.read_not_write(read_not_write),
		.host_addr_low(host_addr_low),
		.host_addr_high(host_addr_high),
		.host_data_in(host_data_in),
		.host_data_out(host_data_out),
		.host_data_oe(host_data_oe),
		.transfer_ack_n(transfer_ack_n),
		.transfer_ack_oe(transfer_ack_oe),
		.acc_wr(acc_wr),
		.acc_addr(acc_addr),
		.acc_wdata(acc_wdata),
		.acc_rdata(acc_rdata)
	);

	// Falling edge of the sampled bit clock
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			clk4_q <= 1'b0;
		else
			clk4_q <= bit_clock_4m;
	end

	assign fall = clk4_q && !bit_clock_4m;

	// Counts falling edges: two per bit cell, 8 cells per channel
	always_comb
	begin
		if (!frame_sync_n)
			edge_d = tsw_pkg::EDGE_CNT_RST; // see R12
		else
			edge_d = edge_q + 1'b1; // see R1 see R15
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			edge_q <= tsw_pkg::EDGE_CNT_RST;
		else if (fall)
			edge_q <= edge_d;
	end

	assign chan_d = edge_d[tsw_pkg::EC_CHAN_MSB:tsw_pkg::EC_CHAN_LSB];
	assign slot_d = edge_d[tsw_pkg::EC_SLOT_MSB:tsw_pkg::EC_SLOT_LSB];

	// Inputs sampled mid-cell, away from the cell boundary edge
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int s = 0; s < tsw_pkg::STREAMS; s++)
				shift_q[s] <= tsw_pkg::BYTE_RST;
		end
		else if (fall && edge_d[0])
		begin
			for (int s = 0; s < tsw_pkg::STREAMS; s++)
				shift_q[s] <= {shift_q[s][6:0], serial_in_streams[s]}; // see R1
		end
	end

	// Completed channel bytes land in the data memory
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < tsw_pkg::MEM_DEPTH; i++)
				dmem_q[i] <= tsw_pkg::BYTE_RST;
		end
		else if (fall && edge_d[0] && slot_d == tsw_pkg::SLOT_LAST)
		begin
			for (int s = 0; s < tsw_pkg::STREAMS; s++)
				dmem_q[cm_index(3'(s), chan_d)] <= {shift_q[s][6:0], serial_in_streams[s]}; // see R15
		end
	end

	// Host decode: line 5 low always reaches the control register
	assign mem_idx = cm_index(ctrl_q[tsw_pkg::CR_STREAM_MSB:tsw_pkg::CR_STREAM_LSB],
		acc_addr[4:0]);
	assign msel = ctrl_q[tsw_pkg::CR_MSEL_MSB:tsw_pkg::CR_MSEL_LSB];

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_q <= tsw_pkg::CR_RST;
		else if (acc_wr && !acc_addr[tsw_pkg::ADDR_MEM_BIT])
			ctrl_q <= acc_wdata; // see R14
	end

	// Split mode sends every memory write to the low connection memory
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < tsw_pkg::MEM_DEPTH; i++)
			begin
				cml_q[i] <= tsw_pkg::BYTE_RST;
				cmh_q[i] <= tsw_pkg::CMH_RST;
			end
		end
		else if (acc_wr && acc_addr[tsw_pkg::ADDR_MEM_BIT])
		begin
			if (ctrl_q[tsw_pkg::CR_SPLIT_BIT] || msel == tsw_pkg::MSEL_CML)
				cml_q[mem_idx] <= acc_wdata;
			else if (msel == tsw_pkg::MSEL_CMH)
				cmh_q[mem_idx] <= acc_wdata[tsw_pkg::CMH_W-1:0];
		end
	end

	// Data memory is read-only from the host; writes to it are dropped
	always_comb
	begin
		acc_rdata = tsw_pkg::BYTE_RST;
		if (!acc_addr[tsw_pkg::ADDR_MEM_BIT])
			acc_rdata = ctrl_q; // see R14
		else if (ctrl_q[tsw_pkg::CR_SPLIT_BIT])
			acc_rdata = dmem_q[mem_idx];
		else if (msel == tsw_pkg::MSEL_CML)
			acc_rdata = cml_q[mem_idx];
		else if (msel == tsw_pkg::MSEL_CMH)
			acc_rdata = {5'h00, cmh_q[mem_idx]};
		else
			acc_rdata = dmem_q[mem_idx];
	end

	// Output bits and enables prepared for the cell that starts next
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_q <= 8'h00;
			oe_q <= 8'h00;
		end
		else if (fall && !edge_d[0])
		begin
			for (int s = 0; s < tsw_pkg::STREAMS; s++)
			begin
				logic [7:0] idx;
				logic [7:0] byte_v;
				idx = cm_index(3'(s), chan_d);
				byte_v = is_message(idx, ctrl_q) ? cml_q[idx] : dmem_q[cml_q[idx]];
				out_q[s] <= byte_v[3'(tsw_pkg::SLOT_LAST - slot_d)]; // see R7 see R15
				oe_q[s] <= ctrl_q[tsw_pkg::CR_MSG_ALL_BIT] || cmh_q[idx][tsw_pkg::CMH_OE_BIT]; // see R10
			end
		end
	end

	// Drive enable gates without delay so release is immediate
	assign serial_out_streams = out_q;
	assign serial_out_oe = output_drive_enable ? oe_q : 8'h00; // see R8 see R9

	// One channel ahead, stream 0 first within the channel
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cso_q <= 1'b0;
		else if (fall && !edge_d[0])
			cso_q <= cmh_q[cm_index(slot_d, chan_d + tsw_pkg::CHAN_ONE)][tsw_pkg::CMH_CSO_BIT]; // see R11
	end

	assign control_serial_out = cso_q;
endmodule
`default_nettype wire

/* tsw_switch_sva.sv */
/*
 Port checker for the time-slot switch pins.
 Assumes one clock domain and that hosts drop strobe between accesses.
*/
`timescale 1ns/1ps
`default_nettype none
module tsw_switch_chk
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic bit_clock_4m,
	input wire logic output_drive_enable,
	input wire logic [7:0] serial_out_streams,
	input wire logic [7:0] serial_out_oe,
	input wire logic chip_sel_n,
	input wire logic data_strobe,
	input wire logic read_not_write,
	input wire logic host_data_oe,
	input wire logic transfer_ack_n,
	input wire logic transfer_ack_oe
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	cs_gate_a: assert property (transfer_ack_oe |-> $past(!chip_sel_n && data_strobe))
		else $error("ack without select");
	rd_drive_a: assert property (host_data_oe |-> !chip_sel_n && read_not_write)
		else $error("data driven outside read");
	rd_data_a: assert property ($rose(transfer_ack_oe) && read_not_write |-> host_data_oe)
		else $error("read ack without data");
	ack_soon_a: assert property ($rose(data_strobe) && !chip_sel_n
		|-> ##[1:4] (transfer_ack_oe || !data_strobe)) else $error("no ack");
	ack_hold_a: assert property (transfer_ack_oe && !chip_sel_n && data_strobe
		|=> transfer_ack_oe) else $error("ack dropped early");
	ack_low_a: assert property (transfer_ack_oe |-> !transfer_ack_n)
		else $error("ack not low");
	ode_off_a: assert property (!output_drive_enable |-> serial_out_oe == 8'h00)
		else $error("stream driven with drive off");
	// Holds for bit clocks whose low phase outlasts the edge detect delay
	cell_edge_a: assert property ($changed(serial_out_streams) |-> !bit_clock_4m)
		else $error("stream moved off cell edge");
	cover property ($rose(transfer_ack_oe) && read_not_write);
	cover property ($rose(transfer_ack_oe) && !read_not_write);
	cover property (output_drive_enable && serial_out_oe != 8'h00);
endmodule
bind tsw_switch tsw_switch_chk chk_u (.clk, .rst_n, .bit_clock_4m, .output_drive_enable,
	.serial_out_streams, .serial_out_oe, .chip_sel_n, .data_strobe, .read_not_write,
	.host_data_oe, .transfer_ack_n, .transfer_ack_oe);
`default_nettype wire

/* tsw_stream_dev.sv */
/*
 Stream side partner: makes bit clock and frame sync, sends random
 input bits and captures one output channel per frame.
 Assumes clk is the 125 MHz system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tsw_stream_dev
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [4:0] rx_ch,
	input wire logic [2:0] rx_st,
	input wire logic [7:0] serial_out_streams,
	input wire logic [7:0] serial_out_oe,
	input wire logic control_serial_out,
	output logic bit_clock_4m,
	output logic frame_sync_n,
	output logic [7:0] serial_in_streams,
	output logic [7:0] rx_byte,
	output logic rx_oe,
	output logic [7:0] rx_cso,
	output logic rx_valid
);
	logic [1:0] div_q;
	logic [8:0] edge_q;
	// Fast bit clock keeps frames short; edges stay far apart in clk terms
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			div_q <= 2'h0;
			bit_clock_4m <= 1'b0;
			edge_q <= 9'h1fd;
			serial_in_streams <= 8'h00;
			rx_valid <= 1'b0;
		end
		else
		begin
			div_q <= div_q + 2'h1;
			rx_valid <= 1'b0;
			if (div_q == 2'h3)
				bit_clock_4m <= !bit_clock_4m;
			if (div_q == 2'h3 && bit_clock_4m)
			begin
				edge_q <= edge_q + 9'h1;
				if (edge_q[0])
					serial_in_streams <= 8'($urandom);
				else if (edge_q[8:4] == rx_ch)
				begin
					rx_byte <= {rx_byte[6:0], serial_out_streams[rx_st]};
					rx_oe <= serial_out_oe[rx_st] & (rx_oe | edge_q[3:1] == 3'h0);
					rx_cso[edge_q[3:1]] <= control_serial_out;
					rx_valid <= edge_q[3:1] == 3'h7;
				end
			end
		end
	assign frame_sync_n = !(edge_q == 9'h1ff && bit_clock_4m
		|| edge_q == 9'h000 && !bit_clock_4m);
endmodule
`default_nettype wire

/* test_tsw_switch.sv */
/*
 Self-checking bench for the time-slot switch pins.
 Assumes the stream partner and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none
module test_tsw_switch;
	logic clk, rst_n, chip_sel_n, data_strobe, read_not_write, output_drive_enable;
	logic bit_clock_4m, frame_sync_n, control_serial_out, host_data_oe;
	logic transfer_ack_n, transfer_ack_oe, rx_oe, rx_valid, ack_d;
	logic [2:0] host_addr_low, host_addr_high, rx_st, s;
	logic [4:0] rx_ch, c;
	logic [7:0] serial_in_streams, serial_out_streams, serial_out_oe, host_data_in;
	logic [7:0] host_data_out, rx_byte, rx_cso, hd, d;
	logic [7:0] exp_q[$];
	int error_cnt, total_checks;
	assign host_data_in = host_data_oe ? host_data_out : hd;
	always #4 clk = !clk;
	tsw_switch dut_u (.clk, .rst_n, .bit_clock_4m, .frame_sync_n, .serial_in_streams,
		.output_drive_enable, .serial_out_streams, .serial_out_oe, .control_serial_out,
		.chip_sel_n, .data_strobe, .read_not_write, .host_addr_low, .host_addr_high,
		.host_data_in, .host_data_out, .host_data_oe, .transfer_ack_n, .transfer_ack_oe);
	tsw_stream_dev dev_u (.clk, .rst_n, .rx_ch, .rx_st, .serial_out_streams, .serial_out_oe,
		.control_serial_out, .bit_clock_4m, .frame_sync_n, .serial_in_streams, .rx_byte,
		.rx_oe, .rx_cso, .rx_valid);
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic cs_n, rnw, input logic [5:0] a, input logic [7:0] v);
		int n;
		@(posedge clk);
		chip_sel_n <= cs_n;
		data_strobe <= 1'b1;
		read_not_write <= rnw;
		{host_addr_high, host_addr_low} <= a;
		hd <= rnw ? ~v : v;
		if (rnw && !cs_n)
			exp_q.push_back(v);
		n = 0;
		do @(posedge clk) n++; while (transfer_ack_oe !== 1'b1 && n < (cs_n ? 4 : 20));
		chk({7'h0, transfer_ack_oe}, {7'h0, !cs_n});
		chip_sel_n <= 1'b1;
		data_strobe <= 1'b0;
		hd <= ~hd;
		repeat (2) @(posedge clk);
	endtask
	task automatic rx(input logic [4:0] ch, input logic [7:0] eb, input logic eoe);
		int n;
		rx_ch <= ch;
		rx_st <= s;
		repeat (2)
		begin
			n = 0;
			do @(posedge clk) n++; while (rx_valid !== 1'b1 && n < 9000);
		end
		if (eoe)
			chk(rx_byte, eb);
		chk({7'h0, rx_oe}, {7'h0, eoe});
	endtask
	// Read data is judged when the acknowledge first appears
	always @(posedge clk)
	begin
		ack_d <= transfer_ack_oe;
		if (transfer_ack_oe === 1'b1 && ack_d !== 1'b1 && host_data_oe === 1'b1)
			chk(host_data_out, exp_q.pop_front());
	end
	task automatic finish_test;
		$display("errors %0d checks %0d", error_cnt, total_checks);
		if (error_cnt == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		finish_test;
	end
	initial
	begin
		{clk, rst_n, chip_sel_n, data_strobe, read_not_write, output_drive_enable} = 6'h2f;
		{host_addr_high, host_addr_low, hd, rx_ch, rx_st, error_cnt, total_checks} = 0;
		void'($urandom(32'h1a8dc619));
		s = 3'($urandom);
		c = 5'($urandom_range(31, 1));
		d = 8'($urandom);
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		bus(0, 0, {1'b0, 5'($urandom)}, {3'h0, 2'h2, s});
		bus(1, 0, 6'h20, 8'hff);
		bus(0, 1, {1'b0, 5'($urandom)}, {3'h0, 2'h2, s});
		bus(0, 0, {1'b1, c}, 8'h07);
		bus(0, 0, 6'h1f, {3'h0, 2'h3, s});
		bus(0, 0, {1'b1, c}, d);
		bus(0, 1, {1'b1, c}, d);
		rx(c, d, 1'b1);
		rx(c - 5'h1, d, 1'b0);
		chk(rx_cso, 8'h01 << s);
		output_drive_enable <= 1'b0;
		rx(c, d, 1'b0);
		output_drive_enable <= 1'b1;
		bus(0, 0, 6'h00, {3'h4, 2'h2, s});
		bus(0, 0, {1'b1, c - 5'h1}, ~d);
		bus(0, 0, 6'h00, {3'h2, 2'h3, s});
		bus(0, 1, {1'b1, c - 5'h1}, ~d);
		rx(c - 5'h1, ~d, 1'b1);
		chk(8'(exp_q.size()), 8'h00);
		finish_test;
	end
endmodule
`default_nettype wire
